// ==== hw/wdrt_params.svh ====
`ifndef WDRT_PARAMS_SVH
`define WDRT_PARAMS_SVH
// ----------------------------------------
// register map and field layout
// ----------------------------------------
`define WDRT_CTRL_ADDR      8'hC0
`define WDRT_CTRL_RESET     8'h00
`define WDRT_BIT_PRE_HI     7
`define WDRT_BIT_PRE_LO     5
`define WDRT_BIT_UNUSED     4
`define WDRT_BIT_REF_FIRST  3
`define WDRT_BIT_REF_SECOND 2
`define WDRT_BIT_STATUS     1
`define WDRT_BIT_ENABLE     0
// ----------------------------------------
// timing
// ----------------------------------------
`define WDRT_CLK_HZ         100000000
`define WDRT_BASE_MS        16
// one counter step: base period split over the 16-bit counter span
// integer division trims the period slightly; pass an exact count if needed
`define WDRT_TICK_CYCLES    ((`WDRT_CLK_HZ / 1000 * `WDRT_BASE_MS) / 65536)
`endif

// ==== hw/wdrt_pkg.sv ====
package wdrt_pkg;
	typedef enum logic [2:0] {
		WDRT_IDLE  = 3'b001,
		WDRT_ARMED = 3'b010,
		WDRT_FIRST = 3'b100
	} wdrt_state_t;
endpackage

// ==== hw/wdrt_prescaler.sv ====
`include "wdrt_params.svh"
module wdrt_prescaler #(
	parameter int TICK_CYCLES = `WDRT_TICK_CYCLES
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// control
	input  wire logic       clear_i,
	input  wire logic [2:0] prescale_i,
	// step output
	output logic            step_o
);
	// ----------------------------------------
	// base tick then power-of-two divider
	// ----------------------------------------
	logic [31:0] base_r;
	logic [6:0]  div_r;
	logic        base_tick;
	logic [7:0]  div_mask;
	assign base_tick = (base_r == 32'(TICK_CYCLES - 1));
	assign div_mask  = (8'h01 << prescale_i) - 8'h01;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			base_r <= 32'h0;
			div_r  <= 7'h00;
			step_o <= 1'b0;
		end else if (clear_i) begin
			base_r <= 32'h0;
			div_r  <= 7'h00;
			step_o <= 1'b0;
		end else begin
			base_r <= base_tick ? 32'h0 : base_r + 32'h1;
			if (base_tick)
				div_r <= div_r + 7'h01;
			step_o <= base_tick && ((div_r & div_mask[6:0]) == div_mask[6:0]);
		end
	end
endmodule

// ==== hw/wdrt_top.sv ====
`include "wdrt_params.svh"
// Function
// - enable low keeps watchdog idle, never resets
// - enabled and expired without refresh asserts system reset
// - timing element is a 16-bit counter scaled by prescale
// - prescale bits 7..5 select 16 ms doubling to 2048 ms
// - timeout sets status bit 1
// - status clears only by writing zero or external reset
// - setting enable starts watchdog and clears counters
// - control resets to zero; single-bit set and clear supported
module wdrt_top #(
	parameter int TICK_CYCLES = `WDRT_TICK_CYCLES
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// register port
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       bit_set_i,
	input  wire logic       bit_clr_i,
	input  wire logic [2:0] bit_sel_i,
	output logic [7:0]      rdata_o,
	// system reset request
	output logic            sys_reset_o
);
	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------
	// register write decode
	// ----------------------------------------
	logic [7:0]  ctrl_r;
	logic [7:0]  ctrl_nxt;
	logic [15:0] count_r;
	logic        sel;
	logic [7:0]  bit_mask;
	logic [7:0]  written;
	logic        any_wr;
	logic        enable_rise;
	logic        refresh_ok;
	logic        expire;
	logic        step;
	wdrt_pkg::wdrt_state_t state_r;
	wdrt_pkg::wdrt_state_t state_nxt;

	assign sel      = (addr_i == `WDRT_CTRL_ADDR);
	assign bit_mask = 8'h01 << bit_sel_i;
	// bit ops and byte write share one merge path
	assign written  = wr_i ? wdata_i :
		bit_set_i ? (ctrl_r | bit_mask) :
		bit_clr_i ? (ctrl_r & ~bit_mask) : ctrl_r;
	assign any_wr   = sel && (wr_i || bit_set_i || bit_clr_i);
	assign enable_rise = any_wr && written[`WDRT_BIT_ENABLE]
		&& !ctrl_r[`WDRT_BIT_ENABLE];
	assign refresh_ok = ctrl_r[`WDRT_BIT_ENABLE] && (state_r == wdrt_pkg::WDRT_FIRST)
		&& ctrl_r[`WDRT_BIT_REF_SECOND];
	assign expire = ctrl_r[`WDRT_BIT_ENABLE] && step && (count_r == 16'hFFFF)
		&& !refresh_ok;

	// ----------------------------------------
	// control register next value
	// ----------------------------------------
	always_comb begin
		ctrl_nxt = any_wr ? written : ctrl_r;
		ctrl_nxt[`WDRT_BIT_UNUSED] = 1'b0;
		if (refresh_ok) begin
			ctrl_nxt[`WDRT_BIT_REF_FIRST]  = 1'b0;
			ctrl_nxt[`WDRT_BIT_REF_SECOND] = 1'b0;
		end
		// set wins over a concurrent software clear
		if (expire)
			ctrl_nxt[`WDRT_BIT_STATUS] = 1'b1;
	end

	// ----------------------------------------
	// refresh order tracker
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			wdrt_pkg::WDRT_IDLE:
				if (ctrl_r[`WDRT_BIT_ENABLE])
					state_nxt = wdrt_pkg::WDRT_ARMED;
			wdrt_pkg::WDRT_ARMED:
				// second bit alone does not count; first must come first
				if (ctrl_r[`WDRT_BIT_REF_FIRST] && !ctrl_r[`WDRT_BIT_REF_SECOND])
					state_nxt = wdrt_pkg::WDRT_FIRST;
			wdrt_pkg::WDRT_FIRST:
				if (refresh_ok)
					state_nxt = wdrt_pkg::WDRT_ARMED;
			default:
				state_nxt = wdrt_pkg::WDRT_IDLE;
		endcase
		if (!ctrl_r[`WDRT_BIT_ENABLE] || enable_rise)
			state_nxt = wdrt_pkg::WDRT_IDLE;
	end

	// ----------------------------------------
	// prescaled 16-bit timeout counter
	// ----------------------------------------
	wdrt_prescaler #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_prescaler (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n),
		.clear_i    (!ctrl_r[`WDRT_BIT_ENABLE] || enable_rise || refresh_ok),
		.prescale_i (ctrl_r[`WDRT_BIT_PRE_HI:`WDRT_BIT_PRE_LO]),
		.step_o     (step)
	);

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	// external reset clears everything, status included; the watchdog's own
	// reset output does not loop back here, so status survives it
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r      <= `WDRT_CTRL_RESET;
			state_r     <= wdrt_pkg::WDRT_IDLE;
			count_r     <= 16'h0000;
			sys_reset_o <= 1'b0;
			rdata_o     <= `WDRT_CTRL_RESET;
		end else begin
			ctrl_r  <= ctrl_nxt;
			state_r <= state_nxt;
			if (!ctrl_r[`WDRT_BIT_ENABLE] || enable_rise || refresh_ok)
				count_r <= 16'h0000;
			else if (step)
				count_r <= count_r + 16'h0001;
			sys_reset_o <= expire;
			rdata_o     <= sel ? ctrl_nxt : 8'h00;
		end
	end
endmodule

// ==== verification/wdrt_checker.sv ====
module wdrt_checker #(
	parameter int TICK_CYCLES = 1
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// register port
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       bit_set_i,
	input  wire logic       bit_clr_i,
	input  wire logic [2:0] bit_sel_i,
	input  wire logic [7:0] rdata_o,
	input  wire logic       sys_reset_o
);
	// ----------------------------------------
	// port relations
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// refresh and status bits excluded: hardware may change them
	wire plain_sel = bit_sel_i inside {3'h0, 3'h5, 3'h6, 3'h7};
	wire sel_c0 = addr_i == 8'hC0;
	a_unused_zero: assert property (!rdata_o[4]) else $error("unused bit set");
	a_other_addr: assert property ($past(addr_i) != 8'hC0 |-> rdata_o == 8'h00)
		else $error("foreign address read nonzero");
	a_byte_write: assert property (sel_c0 && wr_i |=> rdata_o[7:5] == $past(wdata_i[7:5]))
		else $error("byte write lost");
	a_bit_set: assert property (sel_c0 && bit_set_i && !wr_i && plain_sel
		|=> rdata_o[$past(bit_sel_i)]) else $error("bit set lost");
	a_bit_clear: assert property (sel_c0 && bit_clr_i && !wr_i && !bit_set_i && plain_sel
		|=> !rdata_o[$past(bit_sel_i)]) else $error("bit clear lost");
	a_status_fire: assert property (sys_reset_o && $past(addr_i) == 8'hC0 |-> rdata_o[1])
		else $error("status missing at timeout");
	a_status_hold: assert property (sel_c0 && rdata_o[1] && !wr_i && !bit_clr_i |=> rdata_o[1])
		else $error("status dropped");
	a_idle_quiet: assert property ($past(addr_i) == 8'hC0 && !rdata_o[0] |=> !sys_reset_o)
		else $error("reset while disabled");
endmodule

// ==== verification/wdrt_top_tb.sv ====
module wdrt_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// stimulus and model
	// ----------------------------------------
	logic       clk_i = 0, rst_n_i = 0, wr_i = 0, bit_set_i = 0, bit_clr_i = 0;
	logic [7:0] addr_i = 8'hC0, wdata_i = 8'h00, rdata_o;
	logic [2:0] bit_sel_i = 3'h0;
	logic       sys_reset_o;
	int         error_cnt = 0, check_count = 0, n, d;
	// {kind, sel, expected}: kind 2 set, 1 clear, 0 read
	int seq[11] = '{16'h2001, 16'h2309, 16'h220D, 16'h0001, 16'h2205, 16'h230D,
		16'h000D, 16'h1305, 16'h1201, 16'h1000, 16'h2001};
	always #5 clk_i = ~clk_i;
	wdrt_top #(.TICK_CYCLES(1)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wr_i(wr_i), .wdata_i(wdata_i), .bit_set_i(bit_set_i), .bit_clr_i(bit_clr_i),
		.bit_sel_i(bit_sel_i), .rdata_o(rdata_o), .sys_reset_o(sys_reset_o));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task op(input logic [7:0] a, input logic [2:0] k, input logic [2:0] s, input logic [7:0] dt);
		@(posedge clk_i);
		addr_i <= a;
		{wr_i, bit_set_i, bit_clr_i} <= k;
		bit_sel_i <= s;
		wdata_i <= dt;
		@(posedge clk_i);
		{wr_i, bit_set_i, bit_clr_i} <= 3'h0;
		#1;
	endtask
	task conclude;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hE59F1C3E));
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		repeat (4) begin
			d = $urandom;
			op(8'hC0, 3'h4, 3'h0, d[7:0] & 8'hF0);
			chk(rdata_o, d[7:0] & 8'hE0);
		end
		op(8'h5A, 3'h4, 3'h0, 8'hFF);
		chk(rdata_o, 8'h00);
		op(8'hC0, 3'h4, 3'h0, 8'h00);
		foreach (seq[i]) begin
			op(8'hC0, seq[i][14:12], seq[i][10:8], 8'h00);
			chk(rdata_o, seq[i][7:0]);
		end
		// ordered refresh well inside the period; full count restarts from it
		repeat (20000) @(posedge clk_i);
		op(8'hC0, 3'h2, 3'h3, 8'h00);
		chk(rdata_o, 8'h09);
		op(8'hC0, 3'h2, 3'h2, 8'h00);
		chk(rdata_o, 8'h0D);
		// a missed refresh would fire about 20000 cycles early and miss the window
		for (n = 1; n < 70000 && sys_reset_o !== 1'b1; n++) @(posedge clk_i) #1;
		chk({7'h0, n > 65535 && n < 65543}, 8'h01);
		chk(rdata_o, 8'h03);
		@(posedge clk_i) #1;
		chk({7'h0, sys_reset_o}, 8'h00);
		if (n < 70000) begin
			op(8'hC0, 3'h2, 3'h5, 8'h00);
			chk(rdata_o, 8'h23);
			op(8'hC0, 3'h4, 3'h0, 8'h21);
			chk(rdata_o, 8'h21);
		end
		conclude;
	end
endmodule
bind wdrt_top wdrt_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i),
	.bit_set_i(bit_set_i), .bit_clr_i(bit_clr_i), .bit_sel_i(bit_sel_i),
	.rdata_o(rdata_o), .sys_reset_o(sys_reset_o));
